// *** verilog/mck_machine_check.sv ***
// Machine check gathering, exception entry and checkstop with a Wishbone register file
//
// The address map and register access over Wishbone were left to the implementer.
`include "mck_consts.svh"

module mck_machine_check (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic soft_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire mck_pkg::mck_word_t wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic addr_par_err_in,
    input wire logic data_par_err_in,
    input wire logic l1_par_err_in,
    input wire logic l2_par_err_in,
    input wire logic transfer_error_ack_n_in,
    input wire logic machine_check_pin_n_in,
    input wire logic nomem_ref_in,
    input wire logic dcbz_nomem_writeback_in,
    input wire mck_pkg::mck_word_t current_pc_in,
    output logic parity_gen_en_out,
    output logic addr_par_rcv_en_out,
    output logic data_par_rcv_en_out,
    output logic mck_taken_out,
    output logic [31:0] fetch_addr_out,
    output logic checkstop_out,
    output logic run_en_out
);
    import mck_pkg::*;

    typedef struct packed {
        logic [1:0] tea_sync;
        logic [1:0] pin_sync;
        logic [5:0] err_sync0;
        logic [5:0] err_sync1;
        mck_word_t hw_config_0;
        mck_word_t saved_pc;
        mck_word_t saved_state;
        mck_word_t state_word;
        mck_word_t pc_reg;
        logic [7:0] events;
        mck_state_e state;
        logic [1:0] freeze_cnt;
        logic [31:0] dat;
        logic ack;
        logic taken;
        mck_word_t fetch;
        logic cstop;
        logic run;
        logic gen;
        logic arcv;
        logic drcv;
    } mck_regs_s;

    mck_regs_s st_reg;
    mck_regs_s st_next;

    logic [7:0] cause;
    logic addr_par;
    logic data_par;
    logic l1_par;
    logic l2_par;
    logic nomem;
    logic defer;
    logic tea_q;
    logic pin_q;
    logic request;
    logic frozen;
    logic wr;
    logic rd;
    mck_word_t wmask;
    mck_word_t rdata;

    always_comb begin
        st_next = st_reg;
        // Only the second stage of each synchroniser is read
        st_next.tea_sync = {st_reg.tea_sync[0], ~transfer_error_ack_n_in};
        st_next.pin_sync = {st_reg.pin_sync[0], ~machine_check_pin_n_in};
        st_next.err_sync0 = {dcbz_nomem_writeback_in, nomem_ref_in, l2_par_err_in,
                             l1_par_err_in, data_par_err_in, addr_par_err_in};
        st_next.err_sync1 = st_reg.err_sync0;
        addr_par = st_reg.err_sync1[0] & st_reg.hw_config_0[`MCK_CFG_ADDR_CHK];
        data_par = st_reg.err_sync1[1] & st_reg.hw_config_0[`MCK_CFG_DATA_CHK];
        l1_par = st_reg.err_sync1[2];
        l2_par = st_reg.err_sync1[3];
        nomem = st_reg.err_sync1[4];
        // The writeback strobe carries a check deferred from a zeroed block
        defer = st_reg.err_sync1[5];
        // Transfer errors are taken whenever seen, with no instruction ordering
        tea_q = st_reg.tea_sync[1];
        pin_q = st_reg.pin_sync[1] & st_reg.hw_config_0[`MCK_CFG_PIN_MASK];
        cause = {defer, pin_q, tea_q, nomem, l2_par, l1_par, data_par, addr_par};
        request = |cause;
        frozen = (st_reg.state != MCK_RUN);

        st_next.taken = 1'b0;
        st_next.pc_reg = frozen ? st_reg.pc_reg : current_pc_in;
        st_next.gen = st_reg.hw_config_0[`MCK_CFG_PAR_GEN];
        // Receivers stay on unless both generation and checking are off
        st_next.arcv = st_reg.hw_config_0[`MCK_CFG_PAR_GEN]
                       | st_reg.hw_config_0[`MCK_CFG_ADDR_CHK];
        st_next.drcv = st_reg.hw_config_0[`MCK_CFG_PAR_GEN]
                       | st_reg.hw_config_0[`MCK_CFG_DATA_CHK];

        case (st_reg.state)
            MCK_RUN: begin
                if (request && !st_reg.state_word[`MCK_MSW_ME]) begin
                    st_next.state = MCK_FREEZING;
                    st_next.freeze_cnt = 2'h1;
                    st_next.cstop = 1'b1;
                    st_next.run = 1'b0;
                    st_next.events = st_reg.events | cause;
                end else if (request) begin
                    st_next.taken = 1'b1;
                    st_next.events = st_reg.events | cause;
                    st_next.saved_pc = current_pc_in;
                    st_next.saved_state = 32'h0000_0000;
                    st_next.saved_state[`MCK_SS_L2_PAR] = l2_par;
                    st_next.saved_state[`MCK_SS_PIN] = pin_q;
                    st_next.saved_state[`MCK_SS_TEA] = tea_q;
                    st_next.saved_state[`MCK_SS_DATA_PAR] = data_par;
                    st_next.saved_state[`MCK_SS_ADDR_PAR] = addr_par;
                    st_next.saved_state[31:16] = st_reg.state_word[31:16];
                    st_next.state_word = 32'h0000_0000;
                    st_next.state_word[`MCK_MSW_HBO] = st_reg.state_word[`MCK_MSW_HBO];
                    st_next.state_word[`MCK_MSW_VHS] = st_reg.state_word[`MCK_MSW_VHS];
                    st_next.state_word[`MCK_MSW_BOS] = st_reg.state_word[`MCK_MSW_HBO];
                    st_next.fetch = (st_reg.state_word[`MCK_MSW_VHS] ? `MCK_BASE_HIGH
                                     : `MCK_BASE_LOW) | `MCK_VEC_OFFSET;
                end
            end
            MCK_FREEZING: begin
                // Second cycle after entry: everything is held from here on
                st_next.state = MCK_CHECKSTOP;
                st_next.freeze_cnt = 2'(`MCK_FREEZE_CYCLES);
            end
            MCK_CHECKSTOP: begin
                st_next.state = MCK_CHECKSTOP;
            end
            default: begin
                st_next.state = MCK_CHECKSTOP;
            end
        endcase

        // Register bus: one wait state, ack drops the cycle after it is given
        wr = wb_cyc_in & wb_stb_in & wb_we_in & ~st_reg.ack;
        rd = wb_cyc_in & wb_stb_in & ~wb_we_in & ~st_reg.ack;
        wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
        st_next.ack = wb_cyc_in & wb_stb_in & ~st_reg.ack;
        case (wb_adr_in)
            `MCK_OFF_HW_CONFIG_0: rdata = st_reg.hw_config_0;
            `MCK_OFF_SAVED_PC: rdata = st_reg.saved_pc;
            `MCK_OFF_SAVED_STATE: rdata = st_reg.saved_state;
            `MCK_OFF_STATE_WORD: rdata = st_reg.state_word;
            `MCK_OFF_STATUS: rdata = {29'h0, st_reg.run, st_reg.cstop, frozen};
            `MCK_OFF_EVENT: rdata = {24'h00_0000, st_reg.events};
            `MCK_OFF_PC: rdata = st_reg.pc_reg;
            default: rdata = 32'h0000_0000;
        endcase
        if (rd) begin
            st_next.dat = rdata;
        end
        // Writes to the frozen registers are dropped once checkstop begins
        if (wr && !frozen && !(request && st_reg.state == MCK_RUN)) begin
            case (wb_adr_in)
                `MCK_OFF_HW_CONFIG_0: begin
                    // Bit 15 is plain storage, only ever set by software
                    st_next.hw_config_0 = (st_reg.hw_config_0 & ~wmask)
                                          | (wb_dat_in & wmask);
                end
                `MCK_OFF_SAVED_PC: begin
                    st_next.saved_pc = (st_reg.saved_pc & ~wmask) | (wb_dat_in & wmask);
                end
                `MCK_OFF_SAVED_STATE: begin
                    st_next.saved_state = (st_reg.saved_state & ~wmask)
                                          | (wb_dat_in & wmask);
                end
                `MCK_OFF_STATE_WORD: begin
                    st_next.state_word = (st_reg.state_word & ~wmask)
                                         | (wb_dat_in & wmask);
                end
                `MCK_OFF_EVENT: begin
                    // Write one to clear; new causes win over the clear
                    st_next.events = (st_reg.events & ~(wb_dat_in[7:0] & wmask[7:0]))
                                     | cause;
                end
                default: begin
                end
            endcase
        end

        // Soft reset restarts the machine but keeps the no-cold-reset flag
        if (soft_rst_in) begin
            st_next.hw_config_0 = `MCK_CFG_RESET;
            st_next.hw_config_0[`MCK_CFG_NO_COLD] =
                st_reg.hw_config_0[`MCK_CFG_NO_COLD];
            st_next.state_word = `MCK_MSW_RESET;
            st_next.state = MCK_RUN;
            st_next.freeze_cnt = 2'h0;
            st_next.cstop = 1'b0;
            st_next.run = 1'b1;
            st_next.taken = 1'b0;
            st_next.events = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
            st_reg.state <= MCK_RUN;
            st_reg.run <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_out = st_reg.dat;
    assign wb_ack_out = st_reg.ack;
    assign parity_gen_en_out = st_reg.gen;
    assign addr_par_rcv_en_out = st_reg.arcv;
    assign data_par_rcv_en_out = st_reg.drcv;
    assign mck_taken_out = st_reg.taken;
    assign fetch_addr_out = st_reg.fetch;
    assign checkstop_out = st_reg.cstop;
    assign run_en_out = st_reg.run;
endmodule : mck_machine_check

// *** verilog/mck_consts.svh ***
// Offsets, field positions, reset values and vector constants of the machine check block
`ifndef MCK_CONSTS_SVH
`define MCK_CONSTS_SVH

`define MCK_OFF_HW_CONFIG_0 8'h00
`define MCK_OFF_SAVED_PC 8'h04
`define MCK_OFF_SAVED_STATE 8'h08
`define MCK_OFF_STATE_WORD 8'h0C
`define MCK_OFF_STATUS 8'h10
`define MCK_OFF_EVENT 8'h14
`define MCK_OFF_PC 8'h18

`define MCK_CFG_PIN_MASK 0
`define MCK_CFG_PAR_GEN 1
`define MCK_CFG_ADDR_CHK 2
`define MCK_CFG_DATA_CHK 3
`define MCK_CFG_NO_COLD 15

`define MCK_SS_L2_PAR 11
`define MCK_SS_PIN 12
`define MCK_SS_TEA 13
`define MCK_SS_DATA_PAR 14
`define MCK_SS_ADDR_PAR 15

`define MCK_MSW_HBO 16
`define MCK_MSW_ME 19
`define MCK_MSW_VHS 25
`define MCK_MSW_BOS 31

`define MCK_EV_ADDR_PAR 0
`define MCK_EV_DATA_PAR 1
`define MCK_EV_L1_PAR 2
`define MCK_EV_L2_PAR 3
`define MCK_EV_TEA 4
`define MCK_EV_PIN 5
`define MCK_EV_NOMEM 6
`define MCK_EV_DEFER 7

`define MCK_CFG_RESET 32'h0000_0000
`define MCK_MSW_RESET 32'h0000_0000
`define MCK_VEC_OFFSET 32'h0000_0200
`define MCK_BASE_LOW 32'h0000_0000
`define MCK_BASE_HIGH 32'hFFF0_0000
`define MCK_FREEZE_CYCLES 2

`endif

// *** verilog/mck_pkg.sv ***
// Types shared by the machine check block
package mck_pkg;
    typedef logic [31:0] mck_word_t;
    typedef enum logic [1:0] {
        MCK_RUN = 2'b00,
        MCK_FREEZING = 2'b01,
        MCK_CHECKSTOP = 2'b10
    } mck_state_e;
endpackage : mck_pkg

// *** tb/mck_machine_check_assertions.sv ***
// Port-level checker for the machine check block
module mck_checker (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic soft_rst_in,
    input wire logic wb_ack_out,
    input wire logic addr_par_err_in,
    input wire logic l2_par_err_in,
    input wire logic transfer_error_ack_n_in,
    input wire logic parity_gen_en_out,
    input wire logic addr_par_rcv_en_out,
    input wire logic data_par_rcv_en_out,
    input wire logic mck_taken_out,
    input wire logic [31:0] fetch_addr_out,
    input wire logic checkstop_out,
    input wire logic run_en_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    cause_raises_a: assert property (
        ($fell(transfer_error_ack_n_in) || $rose(l2_par_err_in)) && run_en_out
        |-> ##3 (mck_taken_out || checkstop_out)) else $error("cause lost");
    parity_rcv_a: assert property (
        parity_gen_en_out |-> addr_par_rcv_en_out && data_par_rcv_en_out) else $error("rcv off");
    masked_addr_a: assert property (
        $rose(addr_par_err_in) && !addr_par_rcv_en_out && run_en_out
        |-> ##3 !mck_taken_out && !checkstop_out) else $error("masked parity acted");
    stop_no_take_a: assert property (
        checkstop_out |-> !mck_taken_out) else $error("take in checkstop");
    stop_sticky_a: assert property (
        checkstop_out && !soft_rst_in |=> checkstop_out) else $error("checkstop left");
    stop_freeze_a: assert property (
        checkstop_out |-> ##[0:2] !run_en_out) else $error("not frozen");
    take_pulse_a: assert property (mck_taken_out |=> !mck_taken_out)
        else $error("second take");
    fetch_vector_a: assert property (
        mck_taken_out |-> fetch_addr_out inside {32'h0000_0200, 32'hFFF0_0200})
        else $error("bad vector");
    fetch_hold_a: assert property (
        $changed(fetch_addr_out) |-> mck_taken_out || $past(soft_rst_in))
        else $error("fetch moved");
    take_high_c: cover property (mck_taken_out && fetch_addr_out == 32'hFFF0_0200);
    stop_enter_c: cover property ($rose(checkstop_out));
    stop_soft_c: cover property (soft_rst_in && checkstop_out);
endmodule : mck_checker

// *** tb/mck_err_src.sv ***
// Board error logic and memory controller driving the error inputs
module mck_err_src (
    input wire logic sys_clk_in,
    output logic addr_par_out,
    output logic data_par_out,
    output logic l1_par_out,
    output logic l2_par_out,
    output logic tea_n_out,
    output logic pin_n_out,
    output logic nomem_out,
    output logic defer_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] err_reg = 8'h00;
    // Active-low pins are pulled up on the board, so idle reads high
    assign {defer_out, nomem_out, pin_n_out, tea_n_out} = {err_reg[7:6], ~err_reg[5:4]};
    assign {l2_par_out, l1_par_out, data_par_out, addr_par_out} = err_reg[3:0];
    // One-cycle report; a memory error drives nomem_out, separate from the transfer error ack
    task automatic fire(input logic [7:0] m);
        @(posedge sys_clk_in);
        err_reg <= m;
        @(posedge sys_clk_in);
        err_reg <= 8'h00;
    endtask : fire
endmodule : mck_err_src

// *** tb/mck_machine_check_bench.sv ***
// Self-checking bench for the machine check block
`include "mck_consts.svh"
module mck_machine_check_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import mck_pkg::*;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic soft_rst_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'hF;
    mck_word_t wb_dat_in = 32'h0000_0000;
    mck_word_t current_pc_in = 32'h0000_1234;
    logic [31:0] wb_dat_out, fetch_addr_out, rdat;
    logic wb_ack_out, parity_gen_en_out, addr_par_rcv_en_out, data_par_rcv_en_out;
    logic mck_taken_out, checkstop_out, run_en_out, tk, cs;
    logic addr_par_err_in, data_par_err_in, l1_par_err_in, l2_par_err_in;
    logic transfer_error_ack_n_in, machine_check_pin_n_in, nomem_ref_in, dcbz_nomem_writeback_in;
    wire [2:0] par_io = {parity_gen_en_out, addr_par_rcv_en_out, data_par_rcv_en_out};
    int n_fail = 0;
    int compares = 0;
    int i;
    int evb[8] = '{5, 0, 1, 4, 3, 2, 6, 7};
    int cfb[8] = '{0, 2, 3, 1, 1, 1, 1, 1};
    logic [15:0] ssm[8] = '{16'h1000, 16'h8000, 16'h4000, 16'h2000, 16'h0800, 16'h0000,
        16'h0000, 16'h0000};
    mck_machine_check dut (.sys_clk_in, .nrst_in, .soft_rst_in, .wb_cyc_in, .wb_stb_in,
        .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
        .addr_par_err_in, .data_par_err_in, .l1_par_err_in, .l2_par_err_in,
        .transfer_error_ack_n_in, .machine_check_pin_n_in, .nomem_ref_in,
        .dcbz_nomem_writeback_in, .current_pc_in, .parity_gen_en_out, .addr_par_rcv_en_out,
        .data_par_rcv_en_out, .mck_taken_out, .fetch_addr_out, .checkstop_out, .run_en_out);
    mck_err_src src (.sys_clk_in, .addr_par_out(addr_par_err_in), .data_par_out(data_par_err_in),
        .l1_par_out(l1_par_err_in), .l2_par_out(l2_par_err_in),
        .tea_n_out(transfer_error_ack_n_in), .pin_n_out(machine_check_pin_n_in),
        .nomem_out(nomem_ref_in), .defer_out(dcbz_nomem_writeback_in));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Ack is sampled on the rising edge; read data is taken at that same edge
    task automatic bus(input logic we, input logic [7:0] a, input mck_word_t d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, we};
        wb_adr_in <= a;
        wb_dat_in <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 20);
        // A lost ack is counted; the sequence runs on to the closing report
        if (wb_ack_out !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t no ack", $time);
        end
        rdat = wb_dat_out;
        {wb_cyc_in, wb_stb_in, wb_we_in} <= 3'h0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rd
    task automatic watch();
        tk = 1'b0;
        repeat (6) begin
            @(negedge sys_clk_in);
            tk = tk | mck_taken_out;
        end
        cs = checkstop_out;
    endtask : watch
    initial begin
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        @(negedge sys_clk_in);
        chk({checkstop_out, run_en_out}, 2'h1);
        rd(`MCK_OFF_HW_CONFIG_0, 32'h0000_0000);
        // Receivers stay on whenever generation is on; generation off is tried only with checking off
        for (i = 0; i < 8; i++) begin
            if (i[0] || i == 0) begin
                bus(1'b1, `MCK_OFF_HW_CONFIG_0, 32'(i) << 1);
                repeat (2) @(negedge sys_clk_in);
                chk(par_io, {i[0], i[0] | i[1], i[0] | i[2]});
            end
        end
        for (i = 0; i < 8; i++) begin
            bus(1'b1, `MCK_OFF_STATE_WORD, 32'h0008_0000);
            if (i < 3) begin
                bus(1'b1, `MCK_OFF_HW_CONFIG_0, 32'h0000_0000);
                src.fire(8'h01 << evb[i]);
                watch();
                chk({tk, cs}, 2'h0);
            end
            bus(1'b1, `MCK_OFF_HW_CONFIG_0, (32'h1 << cfb[i]) | 32'h2);
            src.fire(8'h01 << evb[i]);
            watch();
            chk({tk, cs}, 2'h2);
            rd(`MCK_OFF_SAVED_STATE, {16'h0008, ssm[i]});
            rd(`MCK_OFF_STATE_WORD, 32'h0000_0000);
            chk(fetch_addr_out, 32'h0000_0200);
        end
        bus(1'b1, `MCK_OFF_HW_CONFIG_0, 32'h0000_800F);
        bus(1'b1, `MCK_OFF_STATE_WORD, 32'h0209_0000);
        src.fire(8'h3B);
        watch();
        chk({tk, cs}, 2'h2);
        rd(`MCK_OFF_SAVED_STATE, 32'h0209_F800);
        rd(`MCK_OFF_STATE_WORD, 32'h8201_0000);
        rd(`MCK_OFF_SAVED_PC, 32'h0000_1234);
        chk(fetch_addr_out, 32'hFFF0_0200);
        // Machine checks now disabled, so a transfer error must stop the core
        src.fire(8'h10);
        watch();
        chk({tk, cs, run_en_out}, 3'h2);
        bus(1'b1, `MCK_OFF_HW_CONFIG_0, 32'h0000_0000);
        rd(`MCK_OFF_HW_CONFIG_0, 32'h0000_800F);
        rd(8'h20, 32'h0000_0000);
        rd(`MCK_OFF_STATUS, 32'h0000_0003);
        rd(`MCK_OFF_EVENT, 32'h0000_00FF);
        current_pc_in <= 32'h0000_5678;
        rd(`MCK_OFF_PC, 32'h0000_1234);
        @(posedge sys_clk_in);
        soft_rst_in <= 1'b1;
        @(posedge sys_clk_in);
        soft_rst_in <= 1'b0;
        @(negedge sys_clk_in);
        chk({checkstop_out, run_en_out}, 2'h1);
        rd(`MCK_OFF_HW_CONFIG_0, 32'h0000_8000);
        wb_sel_in <= 4'h1;
        bus(1'b1, `MCK_OFF_SAVED_PC, 32'hAABB_CCDD);
        wb_sel_in <= 4'hF;
        rd(`MCK_OFF_SAVED_PC, 32'h0000_12DD);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd(`MCK_OFF_HW_CONFIG_0, 32'h0000_0000);
        results();
    end
endmodule : mck_machine_check_bench
bind mck_machine_check mck_checker mon (.sys_clk_in, .nrst_in, .soft_rst_in, .wb_ack_out,
    .addr_par_err_in, .l2_par_err_in, .transfer_error_ack_n_in, .parity_gen_en_out,
    .addr_par_rcv_en_out, .data_par_rcv_en_out, .mck_taken_out, .fetch_addr_out,
    .checkstop_out, .run_en_out);
